// ### cwp_pkg.sv
/*
  cwp_pkg: constants for configuration word decode and memory protection.
  assumes 14-bit nonvolatile words and a 16-bit program/config address space.
*/
package cwp_pkg;
  localparam int unsigned WORD_W       = 14;
  localparam int unsigned ADDR_W       = 16;
  localparam int unsigned WDT_SEL_W    = 5;
  localparam int unsigned WDT_BASE_EXP = 5;
  localparam int unsigned WDT_MAX_CODE = 18;
  localparam int unsigned DIV_EXP_W    = 5;
  // memory config word fields
  localparam int unsigned LVP_BIT      = 13;
  localparam int unsigned SCAN_BIT     = 12;
  localparam int unsigned WRT_LSB      = 0;
  // code protect word fields
  localparam int unsigned PFG_BIT      = 0;
  localparam int unsigned EEG_BIT      = 1;
  localparam logic [13:0] CP_UNIMP_MASK = 14'h3FFC;
  // self-write range tops
  localparam logic [1:0]  WRT_NONE     = 2'h3;
  localparam logic [1:0]  WRT_SMALL    = 2'h2;
  localparam logic [1:0]  WRT_HALF     = 2'h1;
  localparam logic [1:0]  WRT_ALL      = 2'h0;
  localparam logic [15:0] TOP_SMALL    = 16'h01FF;
  localparam logic [15:0] TOP_HALF     = 16'h1FFF;
  localparam logic [15:0] TOP_ALL      = 16'h3FFF;
  // identification space
  localparam logic [15:0] UID_BASE     = 16'h8000;
  localparam logic [15:0] UID_LAST     = 16'h8003;
  localparam logic [15:0] REVID_ADDR   = 16'h8005;
  localparam logic [15:0] PARTID_ADDR  = 16'h8006;
  localparam logic [15:0] MEMCFG_ADDR  = 16'h800A;
  localparam logic [15:0] CPCFG_ADDR   = 16'h800B;
  localparam logic [13:0] WORD_ZERO    = 14'h0000;
endpackage

// ### cwp_config_word_protection.sv
/*
  cwp_config_word_protection: latches configuration words at reset, decodes
  them, and gates self-writes, external access and id/config reads.
  assumes nvm words are stable while sys_rst is high; the external programmer
  pins are synchronised before reaching here.
*/
// Function
// (RQ1) watchdog divider exponent is five plus the 5-bit period code up to 18, codes above 18 give 23
// (RQ2) low-voltage enable set forces shared pin to master clear
// (RQ3) clearing low-voltage enable refused while in low-voltage programming
// (RQ4) high-voltage programming entry always accepted; code accepts it only from PM_IDLE and ignores it while in PM_LV
// (RQ5) scanner available only when avail bit set, then disable governs
// (RQ6) 2-bit range code protects none, 01FFh, 1FFFh or 3FFFh tops
// (RQ7) range blocks only internal writes and erases, never reads
// (RQ8) program guard zero blocks external program access, reads give zero
// (RQ9) cpu program reads pass regardless of protection
// (RQ10) eeprom guard zero blocks external eeprom access, reads give zero
// (RQ11) cpu eeprom reads pass regardless of eeprom guard
// (RQ12) program and eeprom guards act independently
// (RQ13) four user id words at 8000h-8003h writable by software
// (RQ14) part id at 8006h and revision id at 8005h are read-only
// (RQ15) id and config words readable by programmer and nvm control
// (RQ16) unimplemented code protect bits read back as one
// (RQ17) without low-voltage enable, pin enable picks master clear or port
// (RQ18) configuration latched during reset and held until next reset
`timescale 1ns/10ps
module cwp_config_word_protection import cwp_pkg::*; #(
  parameter logic [13:0] PART_ID = 14'h1234, // arbitrary value
  parameter logic [13:0] REV_ID  = 14'h2041  // arbitrary value
) (
  input  wire logic              ref_clk,
  input  wire logic              sys_rst,
  input  wire logic [13:0]       nvmMemCfgWord,
  input  wire logic [13:0]       nvmCpCfgWord,
  input  wire logic [4:0]        wdt_period_select,
  input  wire logic              master_clear_pin_enable,
  input  wire logic              scanner_module_disable,
  input  wire logic              hvProgEntryReq,
  input  wire logic              lvProgEntryReq,
  input  wire logic              progExitReq,
  input  wire logic              extProgAccess,
  input  wire logic              extEeAccess,
  input  wire logic              extWrite,
  input  wire logic              extLvpClearReq,
  input  wire logic [13:0]       extRdMemData,
  input  wire logic              swWrReq,
  input  wire logic [15:0]       swWrAddr,
  input  wire logic              cpuRdReq,
  input  wire logic [13:0]       cpuRdMemData,
  input  wire logic              idRdReq,
  input  wire logic              idWrReq,
  input  wire logic [15:0]       idAddr,
  input  wire logic [13:0]       idWrData,
  output logic [4:0]             wdtDivExp,
  output logic                   master_clear_pin,
  output logic                   scannerEnable,
  output logic                   swWrAllow,
  output logic                   extAccessAllow,
  output logic [13:0]            extRdData,
  output logic [13:0]            cpuRdData,
  output logic [13:0]            idRdData,
  output logic                   progActive,
  output logic                   lvpClearAccept,
  output logic                   low_voltage_prog_enable
);
  typedef enum logic [1:0] {PM_IDLE, PM_LV, PM_HV} cwp_mode_e;
  cwp_mode_e mode_r, mode_nxt;
  logic [13:0] memCfg_r, cpCfg_r;
  logic [4:0]  wdtSel_r;
  logic [13:0] uid_r [4];
  logic [13:0] extRdData_r, cpuRdData_r, idRdData_r;
  logic        lvpKill_r;
  logic        mclrEn_r;

  if (WORD_W != 14 || WDT_SEL_W != 5) begin : g_bad_width
    $error("cwp word widths unsupported");
  end

  // RQ16 RQ18 latch during reset
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      memCfg_r <= nvmMemCfgWord;
      cpCfg_r  <= nvmCpCfgWord | CP_UNIMP_MASK;
      wdtSel_r <= wdt_period_select;
      mclrEn_r <= master_clear_pin_enable;
    end
  end

  // RQ1 divider exponent
  wire [5:0] wdtExpWide = 6'(wdtSel_r) + 6'(WDT_BASE_EXP);
  assign wdtDivExp = (wdtSel_r > 5'(WDT_MAX_CODE)) ? 5'(WDT_MAX_CODE + WDT_BASE_EXP)
                                                   : wdtExpWide[4:0];

  wire lvpOn = memCfg_r[LVP_BIT] & ~lvpKill_r;
  assign low_voltage_prog_enable = lvpOn;
  // RQ2 RQ17 shared pin
  assign master_clear_pin = lvpOn | mclrEn_r;
  // RQ5 scanner gate
  assign scannerEnable = memCfg_r[SCAN_BIT] & ~scanner_module_disable;

  // RQ6 RQ7 self-write range
  wire [1:0]  wrtCode = memCfg_r[WRT_LSB +: 2];
  wire [15:0] wrtTop  = (wrtCode == WRT_SMALL) ? TOP_SMALL :
                        (wrtCode == WRT_HALF)  ? TOP_HALF  : TOP_ALL;
  wire        wrtOpen = (wrtCode == WRT_NONE) |
                        ((wrtCode != WRT_ALL) & (swWrAddr > wrtTop));
  assign swWrAllow = swWrReq & wrtOpen;

  // RQ8 RQ10 RQ12 independent guards
  wire pfgOpen = cpCfg_r[PFG_BIT];
  wire eegOpen = cpCfg_r[EEG_BIT];
  wire extAny  = extProgAccess | extEeAccess;
  wire extOpen = extAny & (~extProgAccess | pfgOpen) & (~extEeAccess | eegOpen);
  assign extAccessAllow = progActive & extOpen;

  // RQ4 program mode entry
  always_comb begin
    mode_nxt = mode_r;
    unique case (mode_r)
      PM_IDLE: begin
        if (hvProgEntryReq) mode_nxt = PM_HV;
        else if (lvProgEntryReq & lvpOn) mode_nxt = PM_LV;
      end
      PM_LV: if (progExitReq) mode_nxt = PM_IDLE;
      PM_HV: if (progExitReq) mode_nxt = PM_IDLE;
    endcase
  end
  assign progActive = (mode_r != PM_IDLE);

  // RQ3 lockout refusal
  assign lvpClearAccept = extLvpClearReq & (mode_r == PM_HV);

  wire uidHit = (idAddr >= UID_BASE) && (idAddr <= UID_LAST);
  wire [13:0] idMux = uidHit                  ? uid_r[idAddr[1:0]] :
                      (idAddr == REVID_ADDR)  ? REV_ID :
                      (idAddr == PARTID_ADDR) ? PART_ID :
                      (idAddr == MEMCFG_ADDR) ? memCfg_r :
                      (idAddr == CPCFG_ADDR)  ? cpCfg_r : WORD_ZERO;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      mode_r      <= PM_IDLE;
      lvpKill_r   <= 1'b0;
      extRdData_r <= WORD_ZERO;
      cpuRdData_r <= WORD_ZERO;
      idRdData_r  <= WORD_ZERO;
    end else begin
      mode_r <= mode_nxt;
      if (lvpClearAccept) lvpKill_r <= 1'b1;
      // RQ8 RQ10 zero on blocked read
      extRdData_r <= (extAccessAllow & ~extWrite) ? extRdMemData : WORD_ZERO;
      // RQ9 RQ11 cpu reads unguarded
      if (cpuRdReq) cpuRdData_r <= cpuRdMemData;
      // RQ14 RQ15 RQ16 id and config reads
      if (idRdReq) idRdData_r <= idMux;
    end
  end
  assign extRdData = extRdData_r;
  assign cpuRdData = cpuRdData_r;
  assign idRdData  = idRdData_r;

  // RQ13 user id storage
  for (genvar i = 0; i < 4; i++) begin : g_uid
    always_ff @(posedge ref_clk) begin
      if (sys_rst) uid_r[i] <= 14'h3FFF;
      else if (idWrReq && uidHit && idAddr[1:0] == 2'(i)) uid_r[i] <= idWrData;
    end
  end

  property p_lvp_pin;
    @(posedge ref_clk) disable iff (sys_rst) lvpOn |-> master_clear_pin;
  endproperty
  a_lvp_pin: assert property (p_lvp_pin) else $error("pin not master clear"); // RQ2
  property p_lvp_refuse;
    @(posedge ref_clk) disable iff (sys_rst) (mode_r == PM_LV) |-> !lvpClearAccept;
  endproperty
  a_lvp_refuse: assert property (p_lvp_refuse) else $error("lvp cleared in lv mode"); // RQ3
  property p_hv_entry;
    @(posedge ref_clk) disable iff (sys_rst)
      (mode_r == PM_IDLE && hvProgEntryReq) |=> (mode_r == PM_HV);
  endproperty
  a_hv_entry: assert property (p_hv_entry) else $error("hv entry refused"); // RQ4
  property p_scan;
    @(posedge ref_clk) disable iff (sys_rst) !memCfg_r[SCAN_BIT] |-> !scannerEnable;
  endproperty
  a_scan: assert property (p_scan) else $error("scanner on while unavailable"); // RQ5
  property p_wrt;
    @(posedge ref_clk) disable iff (sys_rst)
      (swWrReq && wrtCode == 2'h0) |-> !swWrAllow;
  endproperty
  a_wrt: assert property (p_wrt) else $error("write in full protect"); // RQ6
  property p_ext_zero;
    @(posedge ref_clk) disable iff (sys_rst)
      (extProgAccess && !extEeAccess && !pfgOpen) |=> (extRdData == WORD_ZERO);
  endproperty
  a_ext_zero: assert property (p_ext_zero) else $error("guarded read leaked"); // RQ8
  property p_ee_zero;
    @(posedge ref_clk) disable iff (sys_rst)
      (extEeAccess && !extProgAccess && !eegOpen) |=> (extRdData == WORD_ZERO);
  endproperty
  a_ee_zero: assert property (p_ee_zero) else $error("eeprom read leaked"); // RQ10
  property p_cpu_rd;
    @(posedge ref_clk) disable iff (sys_rst)
      cpuRdReq |=> (cpuRdData == $past(cpuRdMemData));
  endproperty
  a_cpu_rd: assert property (p_cpu_rd) else $error("cpu read blocked"); // RQ9
  property p_cp_ones;
    @(posedge ref_clk) disable iff (sys_rst) (cpCfg_r & CP_UNIMP_MASK) == CP_UNIMP_MASK;
  endproperty
  a_cp_ones: assert property (p_cp_ones) else $error("unimplemented bits not one"); // RQ16
  property p_cfg_hold;
    @(posedge ref_clk) disable iff (sys_rst)
      ##1 ($stable(memCfg_r) && $stable(cpCfg_r) && $stable(wdtSel_r) && $stable(mclrEn_r));
  endproperty
  a_cfg_hold: assert property (p_cfg_hold) else $error("config changed"); // RQ18
  property p_div_exp;
    @(posedge ref_clk) disable iff (sys_rst)
      (wdtSel_r <= 5'(WDT_MAX_CODE)) |-> (wdtDivExp == wdtSel_r + 5'(WDT_BASE_EXP));
  endproperty
  a_div_exp: assert property (p_div_exp) else $error("divider exponent wrong"); // RQ1
  property p_div_clamp;
    @(posedge ref_clk) disable iff (sys_rst)
      (wdtSel_r > 5'(WDT_MAX_CODE)) |-> (wdtDivExp == 5'(WDT_MAX_CODE + WDT_BASE_EXP));
  endproperty
  a_div_clamp: assert property (p_div_clamp) else $error("reserved code not clamped"); // RQ1
  property p_lvp_keep;
    @(posedge ref_clk) disable iff (sys_rst)
      (mode_r == PM_LV) |-> low_voltage_prog_enable;
  endproperty
  a_lvp_keep: assert property (p_lvp_keep) else $error("lvp lost in lv mode"); // RQ3
  property p_lv_gate;
    @(posedge ref_clk) disable iff (sys_rst)
      (mode_r == PM_IDLE && lvProgEntryReq && !hvProgEntryReq && !lvpOn) |=> (mode_r == PM_IDLE);
  endproperty
  a_lv_gate: assert property (p_lv_gate) else $error("lv entry without enable"); // RQ4
  property p_scan_on;
    @(posedge ref_clk) disable iff (sys_rst)
      memCfg_r[SCAN_BIT] |-> (scannerEnable == !scanner_module_disable);
  endproperty
  a_scan_on: assert property (p_scan_on) else $error("scanner disable ignored"); // RQ5
  property p_wrt_small;
    @(posedge ref_clk) disable iff (sys_rst)
      (swWrReq && wrtCode == WRT_SMALL) |-> (swWrAllow == (swWrAddr > TOP_SMALL));
  endproperty
  a_wrt_small: assert property (p_wrt_small) else $error("small range wrong"); // RQ6
  property p_wrt_half;
    @(posedge ref_clk) disable iff (sys_rst)
      (swWrReq && wrtCode == WRT_HALF) |-> (swWrAllow == (swWrAddr > TOP_HALF));
  endproperty
  a_wrt_half: assert property (p_wrt_half) else $error("half range wrong"); // RQ6
  property p_wrt_none;
    @(posedge ref_clk) disable iff (sys_rst)
      (wrtCode == WRT_NONE) |-> (swWrAllow == swWrReq);
  endproperty
  a_wrt_none: assert property (p_wrt_none) else $error("write refused unprotected"); // RQ6
  property p_wrt_rd;
    @(posedge ref_clk) disable iff (sys_rst)
      (cpuRdReq && wrtCode == WRT_ALL) |=> (cpuRdData == $past(cpuRdMemData));
  endproperty
  a_wrt_rd: assert property (p_wrt_rd) else $error("read blocked by range"); // RQ7
  property p_ext_block;
    @(posedge ref_clk) disable iff (sys_rst)
      (extProgAccess && !pfgOpen) |-> !extAccessAllow;
  endproperty
  a_ext_block: assert property (p_ext_block) else $error("guarded program open"); // RQ8
  property p_ee_block;
    @(posedge ref_clk) disable iff (sys_rst)
      (extEeAccess && !eegOpen) |-> !extAccessAllow;
  endproperty
  a_ee_block: assert property (p_ee_block) else $error("guarded eeprom open"); // RQ10
  property p_indep;
    @(posedge ref_clk) disable iff (sys_rst)
      (progActive && extProgAccess && !extEeAccess && pfgOpen) |-> extAccessAllow;
  endproperty
  a_indep: assert property (p_indep) else $error("program access not independent"); // RQ12
  property p_indep_ee;
    @(posedge ref_clk) disable iff (sys_rst)
      (progActive && extEeAccess && !extProgAccess && eegOpen) |-> extAccessAllow;
  endproperty
  a_indep_ee: assert property (p_indep_ee) else $error("eeprom access not independent"); // RQ12
  property p_cpu_ee;
    @(posedge ref_clk) disable iff (sys_rst)
      (cpuRdReq && !eegOpen) |=> (cpuRdData == $past(cpuRdMemData));
  endproperty
  a_cpu_ee: assert property (p_cpu_ee) else $error("cpu eeprom read blocked"); // RQ11
  property p_uid_wr;
    @(posedge ref_clk) disable iff (sys_rst)
      (idWrReq && idAddr == UID_BASE) |=> (uid_r[0] == $past(idWrData));
  endproperty
  a_uid_wr: assert property (p_uid_wr) else $error("user id not written"); // RQ13
  property p_pid_rd;
    @(posedge ref_clk) disable iff (sys_rst)
      (idRdReq && idAddr == PARTID_ADDR) |=> (idRdData == PART_ID);
  endproperty
  a_pid_rd: assert property (p_pid_rd) else $error("part id read wrong"); // RQ14
  property p_rid_rd;
    @(posedge ref_clk) disable iff (sys_rst)
      (idRdReq && idAddr == REVID_ADDR) |=> (idRdData == REV_ID);
  endproperty
  a_rid_rd: assert property (p_rid_rd) else $error("revision id read wrong"); // RQ14
  property p_cfg_rd;
    @(posedge ref_clk) disable iff (sys_rst)
      (idRdReq && idAddr == MEMCFG_ADDR) |=> (idRdData == memCfg_r);
  endproperty
  a_cfg_rd: assert property (p_cfg_rd) else $error("config word read wrong"); // RQ15
  property p_master_clear_pin_en;
    @(posedge ref_clk) disable iff (sys_rst)
      !lvpOn |-> (master_clear_pin == mclrEn_r);
  endproperty
  a_master_clear_pin_en: assert property (p_master_clear_pin_en) else $error("pin enable ignored"); // RQ17
endmodule // cwp_config_word_protection

// ### cwp_prog_model.sv
/*
  cwp_prog_model: external programmer driving mode and access pins.
  assumes the bench calls its tasks just after a falling edge.
*/
`timescale 1ns/10ps
module cwp_prog_model (
  input  wire logic        ref_clk,
  output logic             hvProgEntryReq,
  output logic             lvProgEntryReq,
  output logic             progExitReq,
  output logic             extProgAccess,
  output logic             extEeAccess,
  output logic             extWrite,
  output logic             extLvpClearReq,
  output logic [13:0]      extRdMemData
);
  logic [13:0] datR = 14'h0000;
  logic [13:0] idleR = 14'h1555;
  initial {hvProgEntryReq, lvProgEntryReq, progExitReq} = 3'h0;
  initial {extProgAccess, extEeAccess, extWrite, extLvpClearReq} = 4'h0;
  // raw data scrambles while not accessed
  always @(negedge ref_clk) idleR <= ~idleR;
  assign extRdMemData = (extProgAccess | extEeAccess) ? datR : idleR;
  task automatic mode(input logic hv, input logic lv, input logic ex);
    {hvProgEntryReq, lvProgEntryReq, progExitReq} = {hv, lv, ex};
    @(negedge ref_clk);
    {hvProgEntryReq, lvProgEntryReq, progExitReq} = 3'h0;
    @(negedge ref_clk);
  endtask
  task automatic acc(input logic p, e, w, clr, input logic [13:0] d);
    {extProgAccess, extEeAccess, extWrite, extLvpClearReq} = {p, e, w, clr};
    datR = d;
  endtask
endmodule // cwp_prog_model

// ### testbench.sv
/*
  testbench: config decode and protection compared with a bench model.
  assumes 4 ns clock, falling-edge stimulus, sync active-high reset.
*/
`timescale 1ns/10ps
module testbench import cwp_pkg::*; ;
  localparam logic [13:0] PID = 14'h0ABC; // arbitrary value
  localparam logic [13:0] RID = 14'h2A05; // arbitrary value
  logic ref_clk = 0, sys_rst = 1, master_clear_pin_enable, scanner_module_disable;
  logic swWrReq, cpuRdReq, idRdReq, idWrReq, hvProgEntryReq, lvProgEntryReq;
  logic progExitReq, extProgAccess, extEeAccess, extWrite, extLvpClearReq;
  logic master_clear_pin, scannerEnable, swWrAllow, extAccessAllow, progActive;
  logic lvpClearAccept, low_voltage_prog_enable;
  logic [13:0] nvmMemCfgWord, nvmCpCfgWord, extRdMemData, cpuRdMemData, idWrData;
  logic [13:0] extRdData, cpuRdData, idRdData, v, m, c;
  logic [15:0] swWrAddr, idAddr;
  logic [4:0]  wdt_period_select, wdtDivExp, w;
  int          fails = 0, comparisons = 0, t;
  int          uidQ[$];
  cwp_config_word_protection #(.PART_ID(PID), .REV_ID(RID)) cwp_config_word_protection_i (.*);
  cwp_prog_model cwp_prog_model_i (.*);
  always #2 ref_clk = ~ref_clk;
  task automatic cmp(input string n, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic conclude;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic rst(input int n);
    {nvmMemCfgWord, nvmCpCfgWord, wdt_period_select} = {m, c, w};
    sys_rst = 1;
    cyc(n);
    sys_rst = 0;
    {nvmMemCfgWord, nvmCpCfgWord, wdt_period_select} = 33'($urandom);
  endtask
  task automatic idop(input logic wr, input logic [15:0] a, input logic [13:0] d);
    {idRdReq, idWrReq, idAddr, idWrData} = {~wr, wr, a, d};
    cyc(1);
    {idRdReq, idWrReq} = 2'h0;
    cyc(1);
  endtask
  // hang guard, run needs about 780 cycles
  initial begin
    #200000;
    fails++;
    conclude();
  end
  initial begin
    {swWrReq, cpuRdReq, idRdReq, idWrReq, swWrAddr, idAddr, idWrData} = '0;
    {master_clear_pin_enable, scanner_module_disable, cpuRdMemData} = '0;
    {m, c, w} = '0;
    t = $urandom(85382);
    rst(12);
    for (int i = 0; i < 32; i++) begin
      {m, c} = 28'($urandom);
      w = 5'(i);
      {master_clear_pin_enable, scanner_module_disable} = 2'($urandom);
      rst(2);
      t = (m[1:0] == 2) ? 'h1FF : (m[1:0] == 1) ? 'h1FFF : 'h3FFF;
      cyc(1);
      cmp("div", 16'((i > 18) ? 23 : 5 + i), wdtDivExp);
      cmp("master_clear_pin", m[13] | master_clear_pin_enable, master_clear_pin);
      cmp("scan", m[12] & ~scanner_module_disable, scannerEnable);
      for (int k = 0; k < 2; k++) begin
        swWrReq = 1;
        swWrAddr = (m[1:0] == 3) ? 16'($urandom) : 16'(t + k);
        #1 cmp("swwr", (m[1:0] == 2'h3) | (k == 1 && m[1:0] != 2'h0), swWrAllow);
        cyc(1);
      end
      swWrReq = 0;
      {cpuRdReq, cpuRdMemData} = {1'b1, 14'($urandom)};
      v = cpuRdMemData;
      cyc(1);
      cpuRdReq = 0;
      cmp("cpurd", v, cpuRdData);
      cwp_prog_model_i.mode(1, 0, 0);
      cmp("hv", 1, progActive);
      for (int k = 0; k < 2; k++) begin
        v = 14'($urandom);
        cwp_prog_model_i.acc(k == 0, k == 1, 0, 0, v);
        #1 cmp("extok", c[k], extAccessAllow);
        cyc(1);
        cmp("extrd", c[k] ? v : 14'h0000, extRdData);
        cwp_prog_model_i.acc(0, 0, 0, 0, 14'h0000);
        cyc(1);
      end
      cwp_prog_model_i.acc(1, 0, 1, 0, 14'h3FFF);
      cyc(1);
      cmp("extwr", 0, extRdData);
      cwp_prog_model_i.acc(0, 0, 0, 0, 14'h0000);
      idop(0, MEMCFG_ADDR, 0);
      cmp("memcfg", m, idRdData);
      idop(0, PARTID_ADDR, 0);
      cmp("pid", PID, idRdData);
      idop(0, REVID_ADDR, 0);
      cmp("rid", RID, idRdData);
      idop(0, CPCFG_ADDR, 0);
      cmp("cpcfg", c | CP_UNIMP_MASK, idRdData);
      cwp_prog_model_i.mode(0, 0, 1);
    end
    $display("test decode done");
    for (int k = 0; k < 4; k++) begin
      v = 14'($urandom);
      uidQ.push_back(v);
      idop(1, UID_BASE + 16'(k), v);
      idop(0, UID_BASE + 16'(k), 0);
      cmp("uid", 16'(uidQ.pop_front()), idRdData);
    end
    idop(1, PARTID_ADDR, ~PID);
    idop(0, PARTID_ADDR, 0);
    cmp("pidwr", PID, idRdData);
    $display("test userid done");
    {m, c, w, master_clear_pin_enable} = {14'h3FFF, 14'h3FFF, 5'h00, 1'b0};
    rst(2);
    cwp_prog_model_i.mode(0, 1, 0);
    cwp_prog_model_i.acc(0, 0, 0, 1, 14'h0000);
    #1 cmp("lvclr", 0, lvpClearAccept);
    cyc(1);
    cmp("lvp", 1, low_voltage_prog_enable);
    cwp_prog_model_i.acc(0, 0, 0, 0, 14'h0000);
    cwp_prog_model_i.mode(0, 0, 1);
    cwp_prog_model_i.mode(1, 0, 0);
    cwp_prog_model_i.acc(0, 0, 0, 1, 14'h0000);
    #1 cmp("hvclr", 1, lvpClearAccept);
    cyc(1);
    cmp("lvp0", 0, low_voltage_prog_enable);
    cmp("mclr0", 0, master_clear_pin);
    $display("test lvp done");
    conclude();
  end
endmodule // testbench
